// ---- design/rors_params.svh ----
// register offsets, field positions, reset values and codes for relay routing
// assumes a 32-bit apb slave with word-aligned registers
`ifndef RORS_PARAMS_SVH
`define RORS_PARAMS_SVH

// ==========================================
// register byte offsets
`define RORS_OFF_RELAY_SEL 12'h000
`define RORS_OFF_DC_RANGE 12'h004
`define RORS_OFF_LOW_SCALE 12'h008
`define RORS_OFF_HIGH_SCALE 12'h00c
`define RORS_OFF_SP_LIMITS 12'h010
`define RORS_OFF_OUT_FUNC 12'h014
`define RORS_OFF_STATUS 12'h018
`define RORS_OFF_IRQ_STAT 12'h01c
`define RORS_OFF_IRQ_MASK 12'h020
`define RORS_OFF_SETPOINT 12'h024

// ==========================================
// widths and field positions
`define RORS_SEL_W 4
`define RORS_VAL_W 16
`define RORS_OUT_FUNC_W 4
`define RORS_LIM_HI_LSB 16
`define RORS_OUT3_LSB 4
`define RORS_IRQ_W 3

// ==========================================
// reset values
`define RORS_RELAY_SEL_RST 4'h4
`define RORS_DC_RANGE_RST 1'b1
`define RORS_LOW_RST 16'h0000
`define RORS_HIGH_RST 16'hffff
`define RORS_SP_LO_RST 16'h0000
`define RORS_SP_HI_RST 16'hffff
`define RORS_OUT_FUNC_RST 4'h0

// ==========================================
// output function code meaning setpoint retransmission
`define RORS_FUNC_SP_RETRANS 4'h9

// ==========================================
// analogue scale: 4 ma and 20 ma levels in a 16-bit 0..20 ma code
`define RORS_DAC_LIVE_ZERO 16'h3333
`define RORS_DAC_FULL 16'hffff

`endif

// ---- design/rors_pkg.sv ----
// types for the relay routing and retransmission range block
// assumes rors_params.svh is included by the design files
package rors_pkg;
	typedef enum logic [3:0] {
		RORS_SEL_DISABLED = 4'h0,
		RORS_SEL_HEAT = 4'h1,
		RORS_SEL_COOL = 4'h2,
		RORS_SEL_ALM1 = 4'h3,
		RORS_SEL_ALM2 = 4'h4,
		RORS_SEL_ALM3 = 4'h5,
		RORS_SEL_ALM1_INV = 4'h6,
		RORS_SEL_ALM2_INV = 4'h7,
		RORS_SEL_ALM3_INV = 4'h8,
		RORS_SEL_TIMER_END = 4'ha,
		RORS_SEL_TIMER_RUN = 4'hb
	} rors_relay_sel_t;

	typedef enum logic {
		RORS_RANGE_ZERO_BASED = 1'b0,
		RORS_RANGE_LIVE_ZERO = 1'b1
	} rors_dc_range_t;

	typedef enum {
		RORS_SCALE_IDLE,
		RORS_SCALE_MUL,
		RORS_SCALE_DONE
	} rors_scale_state_t;
endpackage

// ---- design/rors_retrans_scaler.sv ----
// setpoint to analogue code scaler for retransmission
// assumes low < high already clipped, one clock, synchronous reset
`include "rors_params.svh"

module rors_retrans_scaler
	import rors_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// scale settings
	input wire logic [15:0] low_scale,
	input wire logic [15:0] high_scale,
	input wire logic [15:0] setpoint,
	input wire logic live_zero,
	// analogue code
	output logic [15:0] dac_code
);
	// ==========================================
	// fraction of span, sequential divide
	rors_scale_state_t state_q;
	logic [31:0] num_q;
	logic [15:0] den_q;
	// one integer bit so setpoint at high scale reaches full span
	logic [16:0] frac_q;
	logic [4:0] cnt_q;
	logic [31:0] rem_q;
	logic [15:0] sp_c;
	logic [32:0] rem_shift;
	logic [31:0] span_c;

	always_comb
	begin
		if (setpoint < low_scale)
			sp_c = low_scale;
		else if (setpoint > high_scale)
			sp_c = high_scale;
		else
			sp_c = setpoint;
		rem_shift = {rem_q, num_q[31]};
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q <= RORS_SCALE_IDLE;
			num_q <= 32'h0;
			den_q <= 16'h0;
			frac_q <= 17'h0;
			cnt_q <= 5'h0;
			rem_q <= 32'h0;
		end
		else
		begin
			case (state_q)
				RORS_SCALE_IDLE:
				begin
					num_q <= {16'(sp_c - low_scale), 16'h0};
					den_q <= high_scale - low_scale;
					rem_q <= 32'h0;
					cnt_q <= 5'h0;
					state_q <= RORS_SCALE_MUL;
				end
				RORS_SCALE_MUL:
				begin
					num_q <= {num_q[30:0], 1'b0};
					if (rem_shift[31:0] >= {16'h0, den_q} && den_q != 16'h0)
					begin
						rem_q <= rem_shift[31:0] - {16'h0, den_q};
						frac_q <= {frac_q[15:0], 1'b1};
					end
					else
					begin
						rem_q <= rem_shift[31:0];
						frac_q <= {frac_q[15:0], 1'b0};
					end
					cnt_q <= cnt_q + 5'h1;
					if (cnt_q == 5'h1f)
						state_q <= RORS_SCALE_DONE;
				end
				RORS_SCALE_DONE:
					state_q <= RORS_SCALE_IDLE;
				default:
					state_q <= RORS_SCALE_IDLE;
			endcase
		end
	end

	// ==========================================
	// map fraction onto selected range
	always_comb
	begin
		if (live_zero)
			span_c = 32'(frac_q) * 32'(16'(`RORS_DAC_FULL - `RORS_DAC_LIVE_ZERO));
		else
			span_c = 32'(frac_q) * 32'(`RORS_DAC_FULL);
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			dac_code <= 16'h0;
		else if (state_q == RORS_SCALE_DONE)
			dac_code <= (live_zero ? `RORS_DAC_LIVE_ZERO : 16'h0) + span_c[31:16];
	end
endmodule

// ---- design/rors_top.sv ----
// relay four routing, dc range and setpoint retransmission scale registers
// assumes apb master on MCLK, synchronous active-high reset, async status pins
//
// Summary of operation
// - heat selection energises relay while loop demands heating.
// - cool selection energises relay while loop demands cooling.
// - plain alarm selection energises relay while that alarm is active.
// - inverted alarm selection de-energises relay while that alarm is active.
// - after reset relay selector holds plain alarm two.
// - timer end selection energises relay once timer has timed out.
// - timer run selection energises relay while timer runs.
// - dc range has zero-based and live-zero codes; live-zero is default.
// - one dc range setting applies to every fitted dc output.
// - dc range is offered only when a dc output is fitted.
// - low retransmission scale is clipped to at least setpoint low limit.
// - high retransmission scale is clipped to at most setpoint high limit.
// - scale values offered only with dc output fitted and retransmission chosen.
// - retransmission output current tracks setpoint between low and high scales.
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`include "rors_params.svh"

module rors_top
	import rors_pkg::*;
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// control loop, alarm and timer status
	input wire logic HEATING_DEMAND_SOURCE,
	input wire logic COOLING_DEMAND_SOURCE,
	input wire logic FIRST_ALARM_SOURCE,
	input wire logic SECOND_ALARM_SOURCE,
	input wire logic THIRD_ALARM_SOURCE,
	input wire logic TIMER_END_SOURCE,
	input wire logic TIMER_RUNNING_SOURCE,
	// fitted hardware straps
	input wire logic DC_OUT3_FITTED,
	// relay and analogue outputs
	output logic RELAY_FOUR_DRIVE,
	output logic TIMER_LOGIC_OUT,
	output logic DC_RANGE_LIVE_ZERO,
	output logic [15:0] DC_OUT3_CODE,
	output logic IRQ
);
	localparam int NSYNC = 8;

	// ==========================================
	// input synchronisers, three stages, change once stage two and three agree
	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] s1_q;
	logic [NSYNC-1:0] s2_q;
	logic [NSYNC-1:0] s3_q;
	logic [NSYNC-1:0] pin_q;

	assign pin_raw = {DC_OUT3_FITTED, TIMER_RUNNING_SOURCE, TIMER_END_SOURCE,
		THIRD_ALARM_SOURCE, SECOND_ALARM_SOURCE, FIRST_ALARM_SOURCE,
		COOLING_DEMAND_SOURCE, HEATING_DEMAND_SOURCE};

	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++)
		begin : g_sync
			always_ff @(posedge MCLK)
			begin
				if (RST)
				begin
					s1_q[gi] <= 1'b0;
					s2_q[gi] <= 1'b0;
					s3_q[gi] <= 1'b0;
					pin_q[gi] <= 1'b0;
				end
				else
				begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
					if (s2_q[gi] == s3_q[gi])
						pin_q[gi] <= s3_q[gi];
				end
			end
		end
	endgenerate

	logic heat_s;
	logic cool_s;
	logic alm1_s;
	logic alm2_s;
	logic alm3_s;
	logic tend_s;
	logic trun_s;
	logic dc_fitted_s;

	assign heat_s = pin_q[0];
	assign cool_s = pin_q[1];
	assign alm1_s = pin_q[2];
	assign alm2_s = pin_q[3];
	assign alm3_s = pin_q[4];
	assign tend_s = pin_q[5];
	assign trun_s = pin_q[6];
	assign dc_fitted_s = pin_q[7];

	// ==========================================
	// apb decode
	logic wr_en;
	logic addr_ok;

	assign wr_en = PSEL & PENABLE & PWRITE;

	always_comb
	begin
		case (PADDR)
			`RORS_OFF_RELAY_SEL, `RORS_OFF_DC_RANGE, `RORS_OFF_LOW_SCALE,
			`RORS_OFF_HIGH_SCALE, `RORS_OFF_SP_LIMITS, `RORS_OFF_OUT_FUNC,
			`RORS_OFF_STATUS, `RORS_OFF_IRQ_STAT, `RORS_OFF_IRQ_MASK,
			`RORS_OFF_SETPOINT:
				addr_ok = 1'b1;
			default:
				addr_ok = 1'b0;
		endcase
	end

	// ==========================================
	// configuration registers
	rors_relay_sel_t relay_sel_q;
	rors_dc_range_t dc_range_q;
	logic [15:0] low_scale_q;
	logic [15:0] high_scale_q;
	logic [15:0] sp_lo_q;
	logic [15:0] sp_hi_q;
	logic [15:0] setpoint_q;
	logic [3:0] out2_func_q;
	logic [3:0] out3_func_q;
	logic [2:0] irq_mask_q;
	logic retrans_sel;

	assign retrans_sel = (out2_func_q == `RORS_FUNC_SP_RETRANS) ||
		(out3_func_q == `RORS_FUNC_SP_RETRANS);

	always_ff @(posedge MCLK)
	begin
		if (RST)
			relay_sel_q <= rors_relay_sel_t'(`RORS_RELAY_SEL_RST);
		else if (wr_en && PADDR == `RORS_OFF_RELAY_SEL)
		begin
			case (PWDATA[3:0])
				RORS_SEL_DISABLED, RORS_SEL_HEAT, RORS_SEL_COOL, RORS_SEL_ALM1,
				RORS_SEL_ALM2, RORS_SEL_ALM3, RORS_SEL_ALM1_INV, RORS_SEL_ALM2_INV,
				RORS_SEL_ALM3_INV, RORS_SEL_TIMER_END, RORS_SEL_TIMER_RUN:
					relay_sel_q <= rors_relay_sel_t'(PWDATA[3:0]);
				default:
					relay_sel_q <= relay_sel_q;
			endcase
		end
	end

	// range writable only while a dc output is fitted
	always_ff @(posedge MCLK)
	begin
		if (RST)
			dc_range_q <= rors_dc_range_t'(`RORS_DC_RANGE_RST);
		else if (wr_en && PADDR == `RORS_OFF_DC_RANGE && dc_fitted_s)
			dc_range_q <= rors_dc_range_t'(PWDATA[0]);
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			sp_lo_q <= `RORS_SP_LO_RST;
			sp_hi_q <= `RORS_SP_HI_RST;
			setpoint_q <= 16'h0;
			out2_func_q <= `RORS_OUT_FUNC_RST;
			out3_func_q <= `RORS_OUT_FUNC_RST;
			irq_mask_q <= 3'h0;
		end
		else if (wr_en)
		begin
			case (PADDR)
				`RORS_OFF_SP_LIMITS:
				begin
					sp_lo_q <= PWDATA[15:0];
					sp_hi_q <= PWDATA[31:16];
				end
				`RORS_OFF_OUT_FUNC:
				begin
					out2_func_q <= PWDATA[3:0];
					out3_func_q <= PWDATA[7:4];
				end
				`RORS_OFF_IRQ_MASK:
					irq_mask_q <= PWDATA[2:0];
				`RORS_OFF_SETPOINT:
					setpoint_q <= PWDATA[15:0];
				default:
					irq_mask_q <= irq_mask_q;
			endcase
		end
	end

	// scale values, clipped on write and whenever limits move
	logic scale_open;
	assign scale_open = dc_fitted_s & retrans_sel;

	always_ff @(posedge MCLK)
	begin
		if (RST)
			low_scale_q <= `RORS_LOW_RST;
		else if (wr_en && PADDR == `RORS_OFF_LOW_SCALE && scale_open)
			low_scale_q <= (PWDATA[15:0] < sp_lo_q) ? sp_lo_q : PWDATA[15:0];
		else if (low_scale_q < sp_lo_q)
			low_scale_q <= sp_lo_q;
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
			high_scale_q <= `RORS_HIGH_RST;
		else if (wr_en && PADDR == `RORS_OFF_HIGH_SCALE && scale_open)
			high_scale_q <= (PWDATA[15:0] > sp_hi_q) ? sp_hi_q : PWDATA[15:0];
		else if (high_scale_q > sp_hi_q)
			high_scale_q <= sp_hi_q;
	end

	// ==========================================
	// relay source selection
	logic relay_d;
	always_comb
	begin
		case (relay_sel_q)
			RORS_SEL_DISABLED: relay_d = 1'b0;
			RORS_SEL_HEAT: relay_d = heat_s;
			RORS_SEL_COOL: relay_d = cool_s;
			RORS_SEL_ALM1: relay_d = alm1_s;
			RORS_SEL_ALM2: relay_d = alm2_s;
			RORS_SEL_ALM3: relay_d = alm3_s;
			RORS_SEL_ALM1_INV: relay_d = ~alm1_s;
			RORS_SEL_ALM2_INV: relay_d = ~alm2_s;
			RORS_SEL_ALM3_INV: relay_d = ~alm3_s;
			RORS_SEL_TIMER_END: relay_d = tend_s;
			RORS_SEL_TIMER_RUN: relay_d = trun_s;
			default: relay_d = 1'b0;
		endcase
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			RELAY_FOUR_DRIVE <= 1'b0;
			TIMER_LOGIC_OUT <= 1'b0;
		end
		else
		begin
			RELAY_FOUR_DRIVE <= relay_d;
			TIMER_LOGIC_OUT <= ((relay_sel_q == RORS_SEL_TIMER_END) && tend_s) ||
				((relay_sel_q == RORS_SEL_TIMER_RUN) && trun_s);
		end
	end

	// ==========================================
	// dc output stage
	logic [15:0] scaled_code;

	rors_retrans_scaler u_scaler (
		.clk(MCLK),
		.rst(RST),
		.low_scale(low_scale_q),
		.high_scale(high_scale_q),
		.setpoint(setpoint_q),
		.live_zero(dc_range_q == RORS_RANGE_LIVE_ZERO),
		.dac_code(scaled_code)
	);

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			DC_RANGE_LIVE_ZERO <= `RORS_DC_RANGE_RST;
			DC_OUT3_CODE <= 16'h0;
		end
		else
		begin
			DC_RANGE_LIVE_ZERO <= (dc_range_q == RORS_RANGE_LIVE_ZERO);
			if (dc_fitted_s && out3_func_q == `RORS_FUNC_SP_RETRANS)
				DC_OUT3_CODE <= scaled_code;
			else
				DC_OUT3_CODE <= 16'h0;
		end
	end

	// ==========================================
	// interrupts: alarm rising edges, set wins over clear
	logic [2:0] alm_prev_q;
	logic [2:0] irq_stat_q;
	logic [2:0] irq_set;

	assign irq_set = {alm3_s, alm2_s, alm1_s} & ~alm_prev_q;

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			alm_prev_q <= 3'h0;
			irq_stat_q <= 3'h0;
			IRQ <= 1'b0;
		end
		else
		begin
			alm_prev_q <= {alm3_s, alm2_s, alm1_s};
			if (wr_en && PADDR == `RORS_OFF_IRQ_STAT)
				irq_stat_q <= (irq_stat_q & ~PWDATA[2:0]) | irq_set;
			else
				irq_stat_q <= irq_stat_q | irq_set;
			IRQ <= |(irq_stat_q & irq_mask_q);
		end
	end

	// ==========================================
	// apb read path, zero-wait
	logic [31:0] rdata_d;
	always_comb
	begin
		case (PADDR)
			`RORS_OFF_RELAY_SEL: rdata_d = {28'h0, relay_sel_q};
			`RORS_OFF_DC_RANGE: rdata_d = {31'h0, dc_range_q};
			`RORS_OFF_LOW_SCALE: rdata_d = {16'h0, low_scale_q};
			`RORS_OFF_HIGH_SCALE: rdata_d = {16'h0, high_scale_q};
			`RORS_OFF_SP_LIMITS: rdata_d = {sp_hi_q, sp_lo_q};
			`RORS_OFF_OUT_FUNC: rdata_d = {24'h0, out3_func_q, out2_func_q};
			`RORS_OFF_STATUS: rdata_d = {22'h0, scale_open, dc_fitted_s, pin_q[6:0],
				RELAY_FOUR_DRIVE};
			`RORS_OFF_IRQ_STAT: rdata_d = {29'h0, irq_stat_q};
			`RORS_OFF_IRQ_MASK: rdata_d = {29'h0, irq_mask_q};
			`RORS_OFF_SETPOINT: rdata_d = {16'h0, setpoint_q};
			default: rdata_d = 32'h0;
		endcase
	end

	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			PRDATA <= 32'h0;
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY <= PSEL & ~PENABLE;
			PSLVERR <= PSEL & ~PENABLE & ~addr_ok;
			if (PSEL && !PENABLE && !PWRITE)
				PRDATA <= rdata_d;
		end
	end
endmodule

// ---- bench/rors_top_assertions.sv ----
// port checker for rors_top: apb handshake, reset state, range and retrans gating
// assumes bind from the bench top file, single MCLK domain, sync active-high RST
module rors_top_assertions
(
	// clock and reset
	input wire logic MCLK,
	input wire logic RST,
	// apb
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// straps and outputs
	input wire logic DC_OUT3_FITTED,
	input wire logic RELAY_FOUR_DRIVE,
	input wire logic TIMER_LOGIC_OUT,
	input wire logic DC_RANGE_LIVE_ZERO,
	input wire logic [15:0] DC_OUT3_CODE,
	input wire logic IRQ
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);

	// ==========================================
	// helpers
	logic [5:0] unfit_q;
	logic rng_wr;
	assign rng_wr = PSEL && PENABLE && PWRITE && PADDR == 12'h004;
	// cycles since the output three strap went low
	always_ff @(posedge MCLK)
	begin
		if (RST || DC_OUT3_FITTED)
			unfit_q <= 6'h00;
		else if (unfit_q != 6'h3f)
			unfit_q <= unfit_q + 6'h01;
	end
	sequence apb_setup;
		PSEL && !PENABLE;
	endsequence
	sequence apb_access;
		PSEL && PENABLE;
	endsequence

	// ==========================================
	// properties
	setup_answer_a: assert property (apb_setup ##1 apb_access |-> PREADY)
		else $error("no ready in access cycle");
	ready_once_a: assert property (PREADY |=> !PREADY)
		else $error("ready longer than one cycle");
	ready_cause_a: assert property (PREADY |-> $past(PSEL && !PENABLE))
		else $error("ready without setup");
	bad_read_a: assert property (PSLVERR |-> PREADY && (PWRITE || PRDATA == 32'h0))
		else $error("error response wrong");
	reset_state_a: assert property (disable iff (1'b0) RST |=> !RELAY_FOUR_DRIVE &&
		!TIMER_LOGIC_OUT && !IRQ && DC_RANGE_LIVE_ZERO && DC_OUT3_CODE == 16'h0000)
		else $error("outputs not at reset state");
	range_write_a: assert property (!$stable(DC_RANGE_LIVE_ZERO) && !$past(RST) |->
		$past(rng_wr) || $past(rng_wr, 2))
		else $error("range moved without a write");
	range_unfit_a: assert property (unfit_q > 6'h07 |-> $stable(DC_RANGE_LIVE_ZERO))
		else $error("range moved while unfitted");
	code_unfit_a: assert property (unfit_q == 6'h3f |-> DC_OUT3_CODE == 16'h0000)
		else $error("code driven while unfitted");
	timer_relay_a: assert property (TIMER_LOGIC_OUT |-> RELAY_FOUR_DRIVE)
		else $error("logic out without relay");
endmodule

// ---- bench/rors_field_load.sv ----
// field side model: relay coil and current loop receiver on output three
// assumes outputs of rors_top sampled on MCLK
module rors_field_load
(
	// clock
	input wire logic clk,
	// from the block
	input wire logic relay_drive,
	input wire logic [15:0] dac_code,
	// observed state
	output logic coil_on,
	output int loop_ua
);
	timeunit 1ns;
	timeprecision 1ps;
	// coil follows drive; loop current in microamps over 0..20 ma
	always_ff @(posedge clk)
	begin
		coil_on <= relay_drive;
		loop_ua <= int'(dac_code) * 20000 / 65535;
	end
endmodule

// ---- bench/rors_top_tb_top.sv ----
// bench top for rors_top: apb master tasks, scenario tasks, field load model
// assumes rors_top, rors_field_load and rors_top_assertions compiled first
module rors_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, err, relay, tlog, live, irq, coil, fitted = 1'b0;
	logic [6:0] src = 7'h00;
	logic [15:0] code;
	int ua, failures = 0, compares = 0;

	always #2 mclk = ~mclk;

	rors_top dut (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .HEATING_DEMAND_SOURCE(src[0]),
		.COOLING_DEMAND_SOURCE(src[1]), .FIRST_ALARM_SOURCE(src[2]),
		.SECOND_ALARM_SOURCE(src[3]), .THIRD_ALARM_SOURCE(src[4]),
		.TIMER_END_SOURCE(src[5]), .TIMER_RUNNING_SOURCE(src[6]),
		.DC_OUT3_FITTED(fitted), .RELAY_FOUR_DRIVE(relay), .TIMER_LOGIC_OUT(tlog),
		.DC_RANGE_LIVE_ZERO(live), .DC_OUT3_CODE(code), .IRQ(irq));
	rors_field_load load (.clk(mclk), .relay_drive(relay), .dac_code(code),
		.coil_on(coil), .loop_ua(ua));

	// ==========================================
	// shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic near(input int got, input int exp);
		compares++;
		if (got > exp + 40 || got < exp - 40)
		begin
			failures++;
			$display("wrong value at %0t: loop %0d ua want %0d", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1 && n < 20)
		begin
			n++;
			@(posedge mclk);
		end
		if (n == 20)
		begin
			failures++;
			$display("wrong value at %0t: no ready", $time);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] q;
		apb(1'b0, a, 32'h0, q);
		check(q, exp);
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset();
		rd(12'h000, 32'h4);
		rd(12'h004, 32'h1);
		check(live, 1'b1);
		rd(12'h030, 32'h0);
		check(err, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_relay();
		logic [43:0] cds = 44'hba876543210;
		logic [43:0] ixs = 44'h65432432100;
		logic e;
		for (int i = 0; i < 11; i++)
		begin
			wr(12'h000, {28'h0, cds[i*4+:4]});
			for (int a = 0; a < 2; a++)
			begin
				src <= a ? 7'h01 << ixs[i*4+:4] : ~(7'h01 << ixs[i*4+:4]);
				repeat (8) @(posedge mclk);
				e = (i == 0) ? 1'b0 : a[0] ^ (i > 5 && i < 9);
				check(coil, e);
				check(tlog, (i > 8) ? e : 1'b0);
			end
		end
		wr(12'h000, 32'h9);
		rd(12'h000, 32'hb);
		$display("test relay done");
	endtask
	task automatic t_range();
		wr(12'h004, 32'h0);
		rd(12'h004, 32'h1);
		fitted <= 1'b1;
		repeat (8) @(posedge mclk);
		wr(12'h004, 32'h0);
		rd(12'h004, 32'h0);
		check(live, 1'b0);
		wr(12'h004, 32'h1);
		$display("test range done");
	endtask
	task automatic t_scale();
		wr(12'h010, 32'h80001000);
		wr(12'h014, 32'h0);
		wr(12'h008, 32'h2000);
		rd(12'h008, 32'h1000);
		rd(12'h00c, 32'h8000);
		wr(12'h014, 32'h90);
		wr(12'h008, 32'h0800);
		rd(12'h008, 32'h1000);
		wr(12'h00c, 32'hc000);
		rd(12'h00c, 32'h8000);
		wr(12'h00c, 32'h7000);
		rd(12'h00c, 32'h7000);
		wr(12'h014, 32'h09);
		wr(12'h008, 32'h1800);
		rd(12'h008, 32'h1800);
		wr(12'h014, 32'h90);
		for (int k = 0; k < 3; k++)
		begin
			wr(12'h024, k == 0 ? 32'h1800 : k == 1 ? 32'h4400 : 32'h7000);
			repeat (80) @(posedge mclk);
			near(ua, 4000 + k * 8000);
		end
		wr(12'h004, 32'h0);
		wr(12'h024, 32'h1800);
		repeat (80) @(posedge mclk);
		check(code, 16'h0000);
		wr(12'h024, 32'h7000);
		repeat (80) @(posedge mclk);
		check(code, 16'hffff);
		fitted <= 1'b0;
		repeat (80) @(posedge mclk);
		check(code, 16'h0000);
		$display("test scale done");
	endtask
	task automatic t_irq();
		src <= 7'h00;
		wr(12'h01c, 32'h7);
		rd(12'h01c, 32'h0);
		wr(12'h020, 32'h1);
		src <= 7'h04;
		repeat (8) @(posedge mclk);
		check(irq, 1'b1);
		rd(12'h01c, 32'h1);
		wr(12'h01c, 32'h1);
		@(posedge mclk);
		check(irq, 1'b0);
		wr(12'h020, 32'h0);
		src <= 7'h00;
		repeat (8) @(posedge mclk);
		src <= 7'h04;
		repeat (8) @(posedge mclk);
		check(irq, 1'b0);
		rd(12'h01c, 32'h1);
		rd(12'h018, 32'h8);
		$display("test irq done");
	endtask

	// ==========================================
	// run control
	task automatic wrap_up();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_relay();
		t_range();
		t_scale();
		t_irq();
		wrap_up();
	end
	initial
	begin
		#80us;
		failures++;
		wrap_up();
	end
endmodule

bind rors_top rors_top_assertions chk (.MCLK(MCLK), .RST(RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .DC_OUT3_FITTED(DC_OUT3_FITTED),
	.RELAY_FOUR_DRIVE(RELAY_FOUR_DRIVE), .TIMER_LOGIC_OUT(TIMER_LOGIC_OUT),
	.DC_RANGE_LIVE_ZERO(DC_RANGE_LIVE_ZERO), .DC_OUT3_CODE(DC_OUT3_CODE), .IRQ(IRQ));
